// >>> design/interrupt_latch_enable_unit.sv
// Interrupt latch, enable and acceptance sequencer of an 8-bit CPU.
// Assumes the CPU core samples on the machine clock, holds off further
// instruction ends while busy_o is high, and gives one-cycle strobes.
//
// Function
// - Each source but soft interrupt has pending latch.
// - Reset forces all pending latches to zero.
// - Pending latches readable at 2E, 3C, 3D.
// - Software writes zero to clear; trap, watchdog excepted.
// - Writing one never sets; reads show pending state.
// - Soft, undefined, trap, watchdog ignore enable flags.
// - Enable group at 2C, 3A, 3B, read/write; 3A bits 1..3 reserved, read zero.
// - Maskable accepted only with master and own enable.
// - Acceptance clears master before stacking; return reloads it.
// - Master is bit0 of 3A; enable/disable instructions.
// - Master flag resets to zero.
// - One enable bit per maskable source, reset zero.
// - Request stays latched until accepted or cleared.
// - Acceptance follows instruction end, lasts eight cycles.
// - Clear master, clear latch, push three, load vector.
// - No maskable acceptance while master is zero.
// - Only status word and program counter stacked.
// - Simultaneous requests resolved by fixed hardware priority.
// - Non-maskable sources also ranked, lowest index first.
// - Requests sampled in final cycle of each instruction.
`timescale 1ns/1ps
module interrupt_latch_enable_unit
#(
  // Vector per source, source 0 in the low 16 bits
  parameter logic [intr_pkg::NUM_SRC*16-1:0] VECTOR_TABLE = {
    16'hFFB0, 16'hFFB2, 16'hFFB4, 16'hFFB6, 16'hFFB8, 16'hFFBA, 16'hFFBC, 16'hFFBE,
    16'hFFE0, 16'hFFE2, 16'hFFE4, 16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEC, 16'hFFEE,
    16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6, 16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFC}
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Interrupt requests, one-cycle pulses; bit 0 has no latch
  input wire logic [intr_pkg::NUM_SRC-1:1] irq_req_i,
  input wire logic soft_irq_i,
  // CPU instruction events
  input wire logic instr_end_i,
  input wire logic enable_irq_instr_i,
  input wire logic disable_irq_instr_i,
  input wire logic return_instr_i,
  input wire logic return_master_i,
  // CPU context for stacking
  input wire logic [7:0] status_word_i,
  input wire logic [15:0] pc_i,
  // Acceptance sequence outputs
  output logic busy_o,
  output logic push_valid_o,
  output logic [7:0] push_data_o,
  output logic pc_load_o,
  output logic [15:0] pc_vector_o,
  output logic [4:0] accepted_src_o,
  output logic master_enable_flag_o
);
  import intr_pkg::*;

  // Registered state
  logic [NUM_SRC-1:0] pending_latch_q, pending_latch_d; // Pending latches
  logic [NUM_SRC-1:0] source_enable_bit_q, source_enable_bit_d; // Enables, bits 4..23 used
  logic master_enable_flag_q, master_enable_flag_d; // Master flag
  accept_state_e state_q, state_d; // Acceptance step
  logic [4:0] src_q, src_d; // Source being accepted
  logic saved_master_q, saved_master_d; // Master value to stack
  logic [7:0] psw_q, psw_d; // Captured status word
  logic [15:0] pc_q, pc_d; // Captured program counter
  logic [7:0] rdata_q, rdata_d; // Read data
  logic push_valid_q, push_valid_d; // Push strobe
  logic [7:0] push_data_q, push_data_d; // Pushed byte
  logic pc_load_q, pc_load_d; // Vector load strobe
  logic [15:0] vector_q, vector_d; // Vector out
  logic busy_q, busy_d; // Sequence in progress

  // Arbitration signals
  logic [NUM_SRC-1:0] candidate; // Requests that may be accepted
  logic found; // Some candidate present
  logic [4:0] winner; // Lowest candidate index
  logic [NUM_SRC-1:0] set_mask; // Latch set events

  // Candidate selection and fixed priority
  always_comb
  begin
    candidate = pending_latch_q;
    candidate[SRC_SOFT] = soft_irq_i;
    // Maskable need master and own enable; first four pass freely
    for (int i = FIRST_MASKABLE; i < NUM_SRC; i++)
    begin
      candidate[i] = pending_latch_q[i] & source_enable_bit_q[i] & master_enable_flag_q;
    end
    found = 1'b0;
    winner = 5'h00;
    // Lowest index wins, including among non-maskable
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (candidate[i])
      begin
        found = 1'b1;
        winner = 5'(i);
      end
    end
  end

  // Request set events; bit 0 never latches
  always_comb
  begin
    set_mask = {irq_req_i, 1'b0};
  end

  // Next-state logic for latches, enables, sequencer and outputs
  always_comb
  begin
    pending_latch_d = pending_latch_q;
    source_enable_bit_d = source_enable_bit_q;
    master_enable_flag_d = master_enable_flag_q;
    state_d = state_q;
    src_d = src_q;
    saved_master_d = saved_master_q;
    psw_d = psw_q;
    pc_d = pc_q;
    rdata_d = rdata_q;
    push_valid_d = 1'b0;
    push_data_d = push_data_q;
    pc_load_d = 1'b0;
    vector_d = vector_q;
    busy_d = busy_q;

    // Register writes
    if (sfr_wr_i)
    begin
      case (sfr_addr_i)
        // Zero clears all but trap and watchdog, one leaves the latch alone
        ADDR_PENDING_LOW:
        begin
          pending_latch_d[7:0] = pending_latch_q[7:0] & (sfr_wdata_i | ~SW_CLEARABLE[7:0]);
        end
        ADDR_PENDING_HIGH:
        begin
          pending_latch_d[15:8] = pending_latch_q[15:8] & (sfr_wdata_i | ~SW_CLEARABLE[15:8]);
        end
        ADDR_PENDING_EXT:
        begin
          pending_latch_d[23:16] = pending_latch_q[23:16] & (sfr_wdata_i | ~SW_CLEARABLE[23:16]);
        end
        // Enable group, bits 1..3 of low byte reserved
        ADDR_ENABLE_LOW:
        begin
          master_enable_flag_d = sfr_wdata_i[MASTER_BIT];
          source_enable_bit_d[7:4] = sfr_wdata_i[7:4];
        end
        ADDR_ENABLE_HIGH:
        begin
          source_enable_bit_d[15:8] = sfr_wdata_i;
        end
        ADDR_ENABLE_EXT:
        begin
          source_enable_bit_d[23:16] = sfr_wdata_i;
        end
        default:
        begin
          // Unmapped addresses ignored
        end
      endcase
    end

    // Enable and disable instructions act on the master flag
    if (enable_irq_instr_i)
    begin
      master_enable_flag_d = 1'b1;
    end
    else if (disable_irq_instr_i)
    begin
      master_enable_flag_d = 1'b0;
    end

    // Return reloads the stacked master value
    if (return_instr_i)
    begin
      master_enable_flag_d = return_master_i;
    end

    // Register reads, one cycle later on sfr_rdata_o
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        ADDR_PENDING_LOW: rdata_d = {pending_latch_q[7:1], 1'b0};
        ADDR_PENDING_HIGH: rdata_d = pending_latch_q[15:8];
        ADDR_PENDING_EXT: rdata_d = pending_latch_q[23:16];
        ADDR_ENABLE_LOW: rdata_d = {source_enable_bit_q[7:4], 3'h0, master_enable_flag_q};
        ADDR_ENABLE_HIGH: rdata_d = source_enable_bit_q[15:8];
        ADDR_ENABLE_EXT: rdata_d = source_enable_bit_q[23:16];
        default: rdata_d = 8'h00;
      endcase
    end

    // Acceptance sequence, eight machine cycles
    case (state_q)
      ST_IDLE:
      begin
        // Sample requests in the instruction's last cycle
        if (instr_end_i && found)
        begin
          state_d = ST_CLR_MASTER;
          src_d = winner;
          saved_master_d = master_enable_flag_d;
          psw_d = status_word_i;
          pc_d = pc_i;
          busy_d = 1'b1;
        end
      end
      ST_CLR_MASTER:
      begin
        master_enable_flag_d = 1'b0;
        state_d = ST_CLR_LATCH;
      end
      ST_CLR_LATCH:
      begin
        pending_latch_d[src_q] = 1'b0;
        state_d = ST_PUSH_PSW;
      end
      ST_PUSH_PSW:
      begin
        // Status word carries the pre-acceptance master flag
        push_valid_d = 1'b1;
        push_data_d = psw_q;
        push_data_d[PSW_MASTER_BIT] = saved_master_q;
        state_d = ST_PUSH_PCH;
      end
      ST_PUSH_PCH:
      begin
        push_valid_d = 1'b1;
        push_data_d = pc_q[15:8];
        state_d = ST_PUSH_PCL;
      end
      ST_PUSH_PCL:
      begin
        push_valid_d = 1'b1;
        push_data_d = pc_q[7:0];
        state_d = ST_LOAD_VEC;
      end
      ST_LOAD_VEC:
      begin
        pc_load_d = 1'b1;
        vector_d = VECTOR_TABLE[src_q*16 +: 16];
        state_d = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        state_d = ST_FINISH;
      end
      ST_FINISH:
      begin
        busy_d = 1'b0;
        state_d = ST_IDLE;
      end
      default:
      begin
        busy_d = 1'b0;
        state_d = ST_IDLE;
      end
    endcase

    // A request arriving during any clear still latches
    pending_latch_d = pending_latch_d | set_mask;
  end

  // State registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      pending_latch_q <= PENDING_RST;
      source_enable_bit_q <= ENABLE_RST;
      master_enable_flag_q <= MASTER_RST;
      state_q <= ST_IDLE;
      src_q <= 5'h00;
      saved_master_q <= 1'b0;
      psw_q <= 8'h00;
      pc_q <= 16'h0000;
      rdata_q <= 8'h00;
      push_valid_q <= 1'b0;
      push_data_q <= 8'h00;
      pc_load_q <= 1'b0;
      vector_q <= 16'h0000;
      busy_q <= 1'b0;
    end
    else
    begin
      pending_latch_q <= pending_latch_d;
      source_enable_bit_q <= source_enable_bit_d;
      master_enable_flag_q <= master_enable_flag_d;
      state_q <= state_d;
      src_q <= src_d;
      saved_master_q <= saved_master_d;
      psw_q <= psw_d;
      pc_q <= pc_d;
      rdata_q <= rdata_d;
      push_valid_q <= push_valid_d;
      push_data_q <= push_data_d;
      pc_load_q <= pc_load_d;
      vector_q <= vector_d;
      busy_q <= busy_d;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata_o = rdata_q;
  assign busy_o = busy_q;
  assign push_valid_o = push_valid_q;
  assign push_data_o = push_data_q;
  assign pc_load_o = pc_load_q;
  assign pc_vector_o = vector_q;
  assign accepted_src_o = src_q;
  assign master_enable_flag_o = master_enable_flag_q;
endmodule // interrupt_latch_enable_unit

// >>> design/intr_pkg.sv
// Constants shared by the interrupt latch and enable unit.
// Assumes an 8-bit special-function register space addressed by byte.
package intr_pkg;
  // Source count and split between non-maskable and maskable sources
  localparam int NUM_SRC = 24;
  localparam int FIRST_MASKABLE = 4;
  // Source indices of the non-maskable group
  localparam int SRC_SOFT = 0;
  localparam int SRC_UNDEF = 1;
  localparam int SRC_TRAP = 2;
  localparam int SRC_WDOG = 3;
  // Register byte addresses
  localparam logic [7:0] ADDR_ENABLE_EXT = 8'h2C;
  localparam logic [7:0] ADDR_PENDING_EXT = 8'h2E;
  localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3A;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3B;
  localparam logic [7:0] ADDR_PENDING_LOW = 8'h3C;
  localparam logic [7:0] ADDR_PENDING_HIGH = 8'h3D;
  // Field positions
  localparam int MASTER_BIT = 0;
  localparam int PSW_MASTER_BIT = 5;
  // Values after reset
  localparam logic [NUM_SRC-1:0] PENDING_RST = 24'h000000;
  localparam logic [NUM_SRC-1:0] ENABLE_RST = 24'h000000;
  localparam logic MASTER_RST = 1'b0;
  // Latches that software writes may clear (all but trap and watchdog)
  localparam logic [NUM_SRC-1:0] SW_CLEARABLE = 24'hFFFFF2;
  // Acceptance takes this many machine cycles
  localparam int ACCEPT_CYCLES = 8;
  // Stack pointer drop during acceptance
  localparam int STACK_PUSHES = 3;
  // Acceptance sequence steps
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CLR_MASTER,
    ST_CLR_LATCH,
    ST_PUSH_PSW,
    ST_PUSH_PCH,
    ST_PUSH_PCL,
    ST_LOAD_VEC,
    ST_SETTLE,
    ST_FINISH
  } accept_state_e;
endpackage

// >>> tb/interrupt_latch_enable_unit_asserts.sv
// Checker for the acceptance sequence and master flag of the unit.
// Sees only the unit's ports; bound to every instance below.
`timescale 1ns/1ps
module interrupt_latch_enable_unit_asserts
  import intr_pkg::*;
#(
  parameter logic [NUM_SRC*16-1:0] VECTOR_TABLE = '0
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Core events
  input wire logic enable_irq_instr_i,
  input wire logic return_instr_i,
  // Sequence outputs
  input wire logic busy_o,
  input wire logic push_valid_o,
  input wire logic [7:0] push_data_o,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_vector_o,
  input wire logic [4:0] accepted_src_o,
  input wire logic master_enable_flag_o
);
  // One clock domain, synchronous reset
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rst; $rose(rst_b_i) |-> !busy_o && !master_enable_flag_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  property p_busy; $rose(busy_o) |-> busy_o[*8] ##1 !busy_o; endproperty
  a_busy: assert property (p_busy) else $error("busy length wrong");
  property p_push; $rose(busy_o) |-> ##3 push_valid_o[*3] ##1 !push_valid_o; endproperty
  a_push: assert property (p_push) else $error("push beats wrong");
  property p_load; $rose(busy_o) |-> !pc_load_o[*6] ##1 pc_load_o ##1 !pc_load_o; endproperty
  a_load: assert property (p_load) else $error("vector load misplaced");
  property p_mclr; $rose(busy_o) |=> !master_enable_flag_o[*7]; endproperty
  a_mclr: assert property (p_mclr) else $error("master not cleared");
  property p_mask; $rose(busy_o) && accepted_src_o >= 5'h04 |-> $past(master_enable_flag_o); endproperty
  a_mask: assert property (p_mask) else $error("masked source taken");
  property p_psw; $rose(push_valid_o) |-> push_data_o[PSW_MASTER_BIT] == $past(master_enable_flag_o, 3); endproperty
  a_psw: assert property (p_psw) else $error("stacked master wrong");
  property p_vec; pc_load_o |-> pc_vector_o == VECTOR_TABLE[accepted_src_o*16 +: 16]; endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_ei; enable_irq_instr_i && !return_instr_i && !busy_o |=> master_enable_flag_o; endproperty
  a_ei: assert property (p_ei) else $error("enable instr ignored");
endmodule // interrupt_latch_enable_unit_asserts

bind interrupt_latch_enable_unit interrupt_latch_enable_unit_asserts #(.VECTOR_TABLE(VECTOR_TABLE)) u_asserts (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .enable_irq_instr_i(enable_irq_instr_i), .return_instr_i(return_instr_i),
  .busy_o(busy_o), .push_valid_o(push_valid_o), .push_data_o(push_data_o), .pc_load_o(pc_load_o),
  .pc_vector_o(pc_vector_o), .accepted_src_o(accepted_src_o), .master_enable_flag_o(master_enable_flag_o));

// >>> tb/cpu_model.sv
// Core model: ends instructions on request, holds the software request.
// Collects bytes pushed during acceptance; runs on the machine clock.
`timescale 1ns/1ps
module cpu_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Bench requests
  input wire logic step_i,
  input wire logic swi_i,
  // From the unit
  input wire logic busy_i,
  input wire logic push_valid_i,
  input wire logic [7:0] push_data_i,
  // To the unit and bench
  output logic instr_end_o,
  output logic soft_irq_o,
  output logic [7:0] status_word_o,
  output logic [15:0] pc_o,
  output logic [7:0] sp_o,
  output logic [23:0] stack_o
);
  assign status_word_o = 8'h0F;
  assign pc_o = 16'h1234;
  // No instruction ends while acceptance runs
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      instr_end_o <= 1'b0;
      soft_irq_o <= 1'b0;
      sp_o <= 8'hFF;
      stack_o <= '0;
    end
    else
    begin
      instr_end_o <= step_i && !busy_i;
      soft_irq_o <= (soft_irq_o || swi_i) && !busy_i;
      if (push_valid_i)
      begin
        sp_o <= sp_o - 8'h01;
        stack_o <= {stack_o[15:0], push_data_i};
      end
    end
  end
endmodule // cpu_model

// >>> tb/interrupt_latch_enable_unit_test.sv
// Bench for the interrupt latch and enable unit.
// The core model stands on the far side of the acceptance port.
`timescale 1ns/1ps
module interrupt_latch_enable_unit_test;
  import intr_pkg::*;
  // Vector of source i is F000 plus twice i
  function automatic logic [NUM_SRC*16-1:0] mk_vt();
    for (int i = 0; i < NUM_SRC; i++)
      mk_vt[i*16 +: 16] = 16'hF000 + (16'(i) << 1);
  endfunction
  localparam logic [NUM_SRC*16-1:0] VT = mk_vt();
  logic mclk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, step = 1'b0, swi = 1'b0;
  logic ei = 1'b0, di = 1'b0, ret = 1'b0, retm = 1'b0, busy, pv, pld, mflag, iend, sirq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pd, sw, sp, sp0;
  logic [23:1] req = '0;
  logic [15:0] vec, pc;
  logic [4:0] acc;
  logic [23:0] stk;
  int fail_count = 0, cmp_count = 0;
  interrupt_latch_enable_unit #(.VECTOR_TABLE(VT)) u_interrupt_latch_enable_unit (
    .mclk_i(mclk), .rst_b_i(rst_b), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .irq_req_i(req), .soft_irq_i(sirq),
    .instr_end_i(iend), .enable_irq_instr_i(ei), .disable_irq_instr_i(di),
    .return_instr_i(ret), .return_master_i(retm), .status_word_i(sw), .pc_i(pc),
    .busy_o(busy), .push_valid_o(pv), .push_data_o(pd), .pc_load_o(pld),
    .pc_vector_o(vec), .accepted_src_o(acc), .master_enable_flag_o(mflag));
  cpu_model u_cpu_model (
    .mclk_i(mclk), .rst_b_i(rst_b), .step_i(step), .swi_i(swi), .busy_i(busy),
    .push_valid_i(pv), .push_data_i(pd), .instr_end_o(iend), .soft_irq_o(sirq),
    .status_word_o(sw), .pc_o(pc), .sp_o(sp), .stack_o(stk));
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register write, one strobe cycle
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Register read, data compared one cycle later
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk("rdata", e, rdata);
  endtask
  // Core instruction pulse: 1 enable, 2 disable, 3 return
  task automatic op(input logic [1:0] k, input logic m);
    @(posedge mclk);
    ei <= (k == 2'h1);
    di <= (k == 2'h2);
    ret <= (k == 2'h3);
    retm <= m;
    @(posedge mclk);
    ei <= 1'b0;
    di <= 1'b0;
    ret <= 1'b0;
  endtask
  task automatic raise(input logic [23:1] v);
    @(posedge mclk);
    req <= v;
    @(posedge mclk);
    req <= '0;
  endtask
  // Ends one instruction and judges the acceptance that follows
  task automatic accept(input int s, input logic take, input logic m);
    int n;
    n = 0;
    sp0 = sp;
    @(posedge mclk);
    step <= 1'b1;
    swi <= (s == 0);
    @(posedge mclk);
    step <= 1'b0;
    swi <= 1'b0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    chk("busy", take, busy);
    if (take)
    begin
      chk("source", s, acc);
      repeat (6) @(negedge mclk);
      chk("pc_load", 1, pld);
      chk("vector", 16'hF000 + (16'(s) << 1), vec);
      repeat (2) @(negedge mclk);
      chk("stack", {2'b00, m, 5'h0F, 16'h1234}, stk);
      chk("sp", sp0 - 8'h03, sp);
      chk("master", 0, mflag);
    end
  endtask
  task automatic t_reset();
    logic [7:0] regs [6];
    regs = '{ADDR_PENDING_LOW, ADDR_PENDING_HIGH, ADDR_PENDING_EXT, ADDR_ENABLE_LOW, ADDR_ENABLE_HIGH, ADDR_ENABLE_EXT};
    foreach (regs[i])
      rdc(regs[i], 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_latch();
    op(2'h2, 1'b0);
    raise('1);
    rdc(8'h3C, 8'hFE);
    rdc(8'h3D, 8'hFF);
    rdc(8'h2E, 8'hFF);
    wrr(8'h3C, 8'h00);
    wrr(8'h3D, 8'h00);
    wrr(8'h2E, 8'h00);
    rdc(8'h3C, 8'h0C);
    wrr(8'h3D, 8'hFF);
    rdc(8'h3D, 8'h00);
    rdc(8'h30, 8'h00);
    $display("t_latch done");
  endtask
  task automatic t_nmi();
    accept(2, 1'b1, 1'b0);
    accept(3, 1'b1, 1'b0);
    rdc(8'h3C, 8'h00);
    $display("t_nmi done");
  endtask
  task automatic t_mask();
    wrr(8'h3A, 8'hF0);
    wrr(8'h3B, 8'hA5);
    wrr(8'h2C, 8'h5A);
    rdc(8'h3B, 8'hA5);
    rdc(8'h2C, 8'h5A);
    wrr(8'h3A, 8'hFF);
    rdc(8'h3A, 8'hF1);
    op(2'h2, 1'b0);
    raise(23'h000190);
    accept(5, 1'b0, 1'b0);
    op(2'h1, 1'b0);
    accept(5, 1'b1, 1'b1);
    op(2'h3, 1'b1);
    @(negedge mclk);
    chk("master", 1, mflag);
    accept(8, 1'b1, 1'b1);
    wrr(8'h3B, 8'hA4);
    op(2'h3, 1'b1);
    accept(9, 1'b0, 1'b1);
    rdc(8'h3D, 8'h02);
    accept(0, 1'b1, 1'b1);
    $display("t_mask done");
  endtask
  // Mid-run reset must wipe latches, enables and master
  task automatic t_rerst();
    raise(23'h000010);
    rdc(8'h3C, 8'h20);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rdc(8'h3C, 8'h00);
    rdc(8'h3D, 8'h00);
    rdc(8'h3A, 8'h00);
    $display("t_rerst done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cuts a hang short
  initial
  begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_latch();
    t_nmi();
    t_mask();
    t_rerst();
    conclude();
  end
endmodule // interrupt_latch_enable_unit_test
